/* card_socket_ctrl.sv */
// top: wishbone registers and two identical socket engines
`timescale 1ns/1ps
`default_nettype none
module card_socket_ctrl
    import card_socket_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [1:0] battery_detect_1,
    input wire logic [1:0] battery_detect_2,
    input wire logic [1:0] card_present_1,
    input wire logic [1:0] card_present_2,
    input wire logic [1:0] ready_irq_in,
    input wire logic [1:0] wait_n,
    input wire logic [1:0] input_acknowledge_n,
    output logic combined_audio_out,
    output logic [1:0] even_byte_select_n,
    output logic [1:0] odd_byte_select_n,
    output logic [1:0] attr_select_n,
    output logic [1:0] output_enable_n,
    output logic [1:0] write_enable_n,
    output logic [1:0] io_read_strobe_n,
    output logic [1:0] io_write_strobe_n,
    output logic [1:0] status_change_pending
);
    // ************************************
    // pin synchronisers
    // ************************************
    logic [13:0] pins_raw, pins_sync;
    assign pins_raw = {battery_detect_1, battery_detect_2, card_present_1, card_present_2,
                       ready_irq_in, wait_n, input_acknowledge_n};
    pin_sync #(.WIDTH(14), .INIT(14'h3fff)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(pins_raw),
        .pin_out(pins_sync)
    );
    logic [1:0] s_batt1, s_batt2, s_cp1, s_cp2, s_rdy, s_wait_n, s_ack_n;
    assign {s_batt1, s_batt2, s_cp1, s_cp2, s_rdy, s_wait_n, s_ack_n} = pins_sync;
    // ************************************
    // wishbone decode
    // ************************************
    logic [31:0] ctrl_reg [2];
    logic [31:0] cyc_reg [2];
    logic req, wr, rd_hit;
    logic [1:0] wr_ctrl, wr_chg, wr_cyc, rd_sel_chg, rd_sel_stat, rd_sel_ctrl, rd_sel_cyc;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign wr_ctrl = {wb_adr_i == CTRL_B_OFF, wb_adr_i == CTRL_A_OFF} & {2{wr}};
    assign wr_chg = {wb_adr_i == CHG_B_OFF, wb_adr_i == CHG_A_OFF} & {2{wr && wb_sel_i[0]}};
    assign wr_cyc = {wb_adr_i == CYC_B_OFF, wb_adr_i == CYC_A_OFF} & {2{wr && wb_sel_i[0]}};
    assign rd_sel_ctrl = {wb_adr_i == CTRL_B_OFF, wb_adr_i == CTRL_A_OFF};
    assign rd_sel_stat = {wb_adr_i == STAT_B_OFF, wb_adr_i == STAT_A_OFF};
    assign rd_sel_chg = {wb_adr_i == CHG_B_OFF, wb_adr_i == CHG_A_OFF};
    assign rd_sel_cyc = {wb_adr_i == CYC_B_OFF, wb_adr_i == CYC_A_OFF};
    assign rd_hit = |{rd_sel_ctrl, rd_sel_stat, rd_sel_chg, rd_sel_cyc};
    // ************************************
    // two socket engines
    // ************************************
    logic [3:0] chg_flags [2];
    logic [7:0] stat [2];
    logic [1:0] busy, ack_seen, audio, chg_event;
    logic [31:0] rd_word [2];
    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_sock
            logic [31:0] ctrl_next;
            always_comb begin
                ctrl_next = ctrl_reg[s];
                for (int b = 0; b < 4; b++) begin
                    if (wb_sel_i[b]) begin
                        ctrl_next[8*b +: 8] = wb_dat_i[8*b +: 8];
                    end
                end
            end
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    ctrl_reg[s] <= CTRL_RESET;
                end else if (wr_ctrl[s]) begin
                    ctrl_reg[s] <= ctrl_next;
                end
            end
            // writes to the cycle register while busy are dropped
            assign cyc_reg[s] = {22'h0, ack_seen[s], busy[s], 8'h00};
            socket_engine u_eng (
                .clk(clk),
                .reset_n(reset_n),
                .io_mode(ctrl_reg[s][CTRL_IO_MODE_BIT]),
                .audio_en(ctrl_reg[s][CTRL_AUDIO_EN_BIT]),
                .chg_enable(ctrl_reg[s][CTRL_EN_LSB +: 4]),
                .chg_clear(wr_chg[s]),
                .chg_clear_mask(wb_dat_i[3:0]),
                .start(wr_cyc[s] && !busy[s]),
                .kind(wb_dat_i[CYC_KIND_LSB +: 2]),
                .attr(wb_dat_i[CYC_ATTR_BIT]),
                .even_req(wb_dat_i[CYC_EVEN_BIT]),
                .odd_req(wb_dat_i[CYC_ODD_BIT]),
                .battery_detect_1(s_batt1[s]),
                .battery_detect_2(s_batt2[s]),
                .card_present_1(s_cp1[s]),
                .card_present_2(s_cp2[s]),
                .ready_irq_in(s_rdy[s]),
                .wait_n(s_wait_n[s]),
                .input_acknowledge_n(s_ack_n[s]),
                .chg_flags(chg_flags[s]),
                .chg_event(chg_event[s]),
                .status(stat[s]),
                .busy(busy[s]),
                .ack_seen(ack_seen[s]),
                .audio(audio[s]),
                .even_byte_select_n(even_byte_select_n[s]),
                .odd_byte_select_n(odd_byte_select_n[s]),
                .attr_select_n(attr_select_n[s]),
                .output_enable_n(output_enable_n[s]),
                .write_enable_n(write_enable_n[s]),
                .io_read_strobe_n(io_read_strobe_n[s]),
                .io_write_strobe_n(io_write_strobe_n[s])
            );
            assign rd_word[s] = ({32{rd_sel_ctrl[s]}} & ctrl_reg[s])
                              | ({32{rd_sel_stat[s]}} & {24'h0, stat[s]})
                              | ({32{rd_sel_chg[s]}} & {28'h0, chg_flags[s]})
                              | ({32{rd_sel_cyc[s]}} & cyc_reg[s]);
        end
    endgenerate
    // ************************************
    // bus answer and merged outputs
    // ************************************
    logic [31:0] rd_data;
    assign rd_data = rd_hit ? (rd_word[0] | rd_word[1]) : 32'h0000_0000;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            combined_audio_out <= 1'b0;
            status_change_pending <= 2'h0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_data : 32'h0000_0000;
            // binary audio: exclusive-or keeps both cards audible
            combined_audio_out <= audio[0] ^ audio[1];
            status_change_pending <= {|chg_flags[1], |chg_flags[0]};
        end
    end
endmodule
`default_nettype wire

/* card_socket_ctrl_sva.sv */
// assertion checker for the two-socket card control block
`timescale 1ns/1ps
`default_nettype none
module card_socket_ctrl_sva
    import card_socket_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [1:0] wait_n,
    input wire logic [1:0] even_byte_select_n,
    input wire logic [1:0] odd_byte_select_n,
    input wire logic [1:0] attr_select_n,
    input wire logic [1:0] output_enable_n,
    input wire logic [1:0] write_enable_n,
    input wire logic [1:0] io_read_strobe_n,
    input wire logic [1:0] io_write_strobe_n
);
    // ************
    // strobe causes
    // ************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a strobe may only start on the edge that acks a cycle-register write
    wire logic wr_a = wb_ack_o && wb_we_i && wb_adr_i == CYC_A_OFF;
    wire logic wr_b = wb_ack_o && wb_we_i && wb_adr_i == CYC_B_OFF;
    AST_MEM_RD: assert property ($fell(output_enable_n[0]) |-> wr_a && wb_dat_i[1:0] == 2'h0)
        else $error("read enable fell without memory read request");
    AST_MEM_WR: assert property ($fell(write_enable_n[0]) |-> wr_a && wb_dat_i[1:0] == 2'h1)
        else $error("write enable fell without memory write request");
    AST_IO_RD: assert property ($fell(io_read_strobe_n[0]) |-> wr_a && wb_dat_i[1:0] == 2'h2)
        else $error("io read strobe fell without io read request");
    AST_IO_WR_B: assert property ($fell(io_write_strobe_n[1]) |-> wr_b && wb_dat_i[1:0] == 2'h3)
        else $error("socket b io write strobe fell without request");
    AST_EVEN_SEL: assert property ($fell(even_byte_select_n[0]) |-> wr_a && wb_dat_i[3])
        else $error("even select fell without even request");
    // selects are held one cycle past the strobe so the card sees them stable at release
    AST_SEL_REL: assert property ($rose(output_enable_n[0]) |=> even_byte_select_n[0] && odd_byte_select_n[0])
        else $error("selects still low after read enable rose");
    AST_ATTR_MEM: assert property ($fell(output_enable_n[0]) |-> attr_select_n[0] == !wb_dat_i[2])
        else $error("attribute select wrong for memory read");
    AST_ATTR_IO: assert property (!io_read_strobe_n[0] |-> !attr_select_n[0])
        else $error("attribute select high during io read");
    AST_WR_WIDTH: assert property ($fell(write_enable_n[0]) |-> ##18 !write_enable_n[0])
        else $error("write enable pulse too short");
    AST_WAIT_HOLD: assert property (!wait_n[0] [*4] ##0 !output_enable_n[0] |=> !output_enable_n[0])
        else $error("read enable released while wait held");
    AST_BUS_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acked next cycle");
endmodule
`default_nettype wire

/* card_socket_pkg.sv */
// shared constants for the two-socket 16-bit card control block
`default_nettype none
package card_socket_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_A_OFF = 8'h00;
    localparam logic [7:0] CTRL_B_OFF = 8'h04;
    localparam logic [7:0] STAT_A_OFF = 8'h08;
    localparam logic [7:0] STAT_B_OFF = 8'h0c;
    localparam logic [7:0] CHG_A_OFF = 8'h10;
    localparam logic [7:0] CHG_B_OFF = 8'h14;
    localparam logic [7:0] CYC_A_OFF = 8'h18;
    localparam logic [7:0] CYC_B_OFF = 8'h1c;
    // control register fields
    localparam int CTRL_IO_MODE_BIT = 0;
    localparam int CTRL_AUDIO_EN_BIT = 1;
    localparam int CTRL_EN_LSB = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // change/enable bit positions (low nibble of status-change register)
    localparam int CHG_DETECT_BIT = 0;
    localparam int CHG_BATT_DEAD_BIT = 1;
    localparam int CHG_BATT_WEAK_BIT = 2;
    localparam int CHG_READY_BIT = 3;
    // cycle register fields
    localparam int CYC_KIND_LSB = 0;
    localparam int CYC_ATTR_BIT = 2;
    localparam int CYC_EVEN_BIT = 3;
    localparam int CYC_ODD_BIT = 4;
    localparam int CYC_BUSY_BIT = 8;
    localparam int CYC_ACK_BIT = 9;
    // cycle kinds
    typedef enum logic [1:0] {
        KIND_MEM_RD = 2'h0,
        KIND_MEM_WR = 2'h1,
        KIND_IO_RD = 2'h2,
        KIND_IO_WR = 2'h3
    } cycle_kind_t;
    // strobe timing
    localparam int CLK_MHZ = 200;
    localparam int STROBE_NS = 100;
    localparam int STROBE_CYCLES = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] STROBE_COUNT = 8'(STROBE_CYCLES);
endpackage
`default_nettype wire

/* pc_card_16bit_socket_control_tb_top.sv */
// self-checking bench for the two-socket card control block
`timescale 1ns/1ps
`default_nettype none
module pc_card_16bit_socket_control_tb_top;
    import card_socket_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, combined_audio_out;
    logic [1:0] even_byte_select_n, odd_byte_select_n, attr_select_n, output_enable_n;
    logic [1:0] write_enable_n, io_read_strobe_n, io_write_strobe_n, status_change_pending;
    wire logic [1:0] battery_detect_1, battery_detect_2, card_present_1, card_present_2;
    wire logic [1:0] ready_irq_in, wait_n, input_acknowledge_n;
    logic [1:0] ins = 2'h0, ioc = 2'h0, ready = 2'h3, irq_n = 2'h3, sts_n = 2'h3, aud = 2'h0;
    logic [1:0] batt [2] = '{2'h3, 2'h3};
    logic [7:0] wlen [2] = '{8'h00, 8'h00};
    int n_mismatch = 0;
    int tests_run = 0;
    card_socket_ctrl i_card_socket_ctrl (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .battery_detect_1,
        .battery_detect_2, .card_present_1, .card_present_2, .ready_irq_in, .wait_n,
        .input_acknowledge_n, .combined_audio_out, .even_byte_select_n, .odd_byte_select_n,
        .attr_select_n, .output_enable_n, .write_enable_n, .io_read_strobe_n,
        .io_write_strobe_n, .status_change_pending);
    for (genvar g = 0; g < 2; g++) begin : g_card
        pc_card_model i_pc_card_model (.clk, .inserted(ins[g]), .io_card(ioc[g]),
            .batt(batt[g]), .ready(ready[g]), .irq_n(irq_n[g]), .change_n(sts_n[g]),
            .audio(aud[g]), .wait_len(wlen[g]), .oe_n(output_enable_n[g]),
            .we_n(write_enable_n[g]), .io_rd_n(io_read_strobe_n[g]),
            .io_wr_n(io_write_strobe_n[g]), .batt_1(battery_detect_1[g]),
            .batt_2(battery_detect_2[g]), .present_1(card_present_1[g]),
            .present_2(card_present_2[g]), .rdy_irq(ready_irq_in[g]), .wait_n(wait_n[g]),
            .ack_n(input_acknowledge_n[g]));
    end
    // ************
    // shared tasks
    // ************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // request held until ack is sampled high; data taken and request dropped at that edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    task automatic wait_idle(input int s);
        int n;
        n = 0;
        do begin
            wb(1'b0, CYC_A_OFF + 8'(4 * s), 32'h0);
            n++;
        end while (rd[CYC_BUSY_BIT] !== 1'b0 && n < 40);
        check("busy", {31'h0, n < 40}, 32'h1);
        if (n >= 40) begin
            give_verdict();
        end
        check("release", {26'h0, output_enable_n[s], write_enable_n[s], io_read_strobe_n[s],
            io_write_strobe_n[s], even_byte_select_n[s], odd_byte_select_n[s]}, 32'h3f);
    endtask
    // flags: bit0 attribute, bit1 even byte, bit2 odd byte
    task automatic card_cycle(input int s, input logic [1:0] kind, input logic [2:0] flags);
        wb(1'b1, CYC_A_OFF + 8'(4 * s), {27'h0, flags, kind});
        #1;
        check("strobes", {28'h0, io_write_strobe_n[s], io_read_strobe_n[s], write_enable_n[s],
            output_enable_n[s]}, {28'h0, ~(4'h1 << kind)});
        check("attr", {31'h0, attr_select_n[s]}, {31'h0, ~(flags[0] | kind[1])});
        check("even", {31'h0, even_byte_select_n[s]}, {31'h0, ~flags[1]});
        check("odd", {31'h0, odd_byte_select_n[s]}, {31'h0, ~flags[2]});
        wait_idle(s);
    endtask
    // ************
    // scenarios
    // ************
    task automatic t_cycles();
        for (int s = 0; s < 2; s++)
            for (int k = 0; k < 4; k++)
                card_cycle(s, 2'(k), 3'(2 * k + s + 2));
        $display("cycles test done");
    endtask
    task automatic t_wait();
        int n;
        n = 0;
        ins[0] <= 1'b1;
        wlen[0] <= 8'd40;
        wb(1'b1, CYC_A_OFF, 32'h8);
        while (output_enable_n[0] === 1'b0 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("wait", {31'h0, n > 40 && n < 300}, 32'h1);
        if (n >= 300) begin
            give_verdict();
        end
        wait_idle(0);
        wlen[0] <= 8'd0;
        $display("wait test done");
    endtask
    task automatic t_status();
        logic [1:0] lv [3] = '{2'h3, 2'h1, 2'h0};
        ins[0] <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            batt[0] <= lv[i];
            repeat (6) @(posedge clk);
            wb(1'b0, STAT_A_OFF, 32'h0);
            check("present", {30'h0, rd[1:0]}, 32'h0);
            check("battery", {29'h0, rd[5:3]}, 32'(3'h4 >> i));
        end
        for (int r = 0; r < 2; r++) begin
            ready[0] <= r[0];
            repeat (6) @(posedge clk);
            wb(1'b0, STAT_A_OFF, 32'h0);
            check("ready", {31'h0, rd[2]}, 32'(r));
        end
        wb(1'b0, CHG_A_OFF, 32'h0);
        check("chg masked", rd, 32'h0);
        wb(1'b1, CTRL_B_OFF, 32'h10);
        ins[1] <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check("pending", {30'h0, status_change_pending}, 32'h2);
        wb(1'b1, CHG_B_OFF, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        check("cleared", {30'h0, status_change_pending}, 32'h0);
        $display("status test done");
    endtask
    task automatic t_audio();
        wb(1'b1, CTRL_A_OFF, 32'h3);
        wb(1'b1, CTRL_B_OFF, 32'h3);
        ioc <= 2'h3;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            aud <= 2'(i);
            repeat (5) @(posedge clk);
            #1;
            check("audio", {31'h0, combined_audio_out}, {31'h0, ^2'(i)});
        end
        wb(1'b1, CTRL_A_OFF, 32'h0);
        irq_n[1] <= 1'b0;
        sts_n[1] <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check("audio mem", {31'h0, combined_audio_out}, 32'h1);
        wb(1'b0, STAT_B_OFF, 32'h0);
        check("irq", {31'h0, rd[7]}, 32'h1);
        check("change", {31'h0, rd[6]}, 32'h1);
        card_cycle(1, 2'h2, 3'h6);
        check("input_acknowledge", {31'h0, rd[CYC_ACK_BIT]}, 32'h1);
        $display("audio test done");
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (11) @(posedge clk);
        #1;
        check("reset", {14'h0, even_byte_select_n, odd_byte_select_n, attr_select_n,
            output_enable_n, write_enable_n, io_read_strobe_n, io_write_strobe_n,
            combined_audio_out, status_change_pending, wb_ack_o}, 32'h3fff0);
        @(posedge clk);
        reset_n <= 1'b1;
        wb(1'b0, CTRL_A_OFF, 32'h0);
        check("ctrl reset", rd, CTRL_RESET);
        wb(1'b0, 8'h40, 32'h0);
        check("unmapped", rd, 32'h0);
        t_cycles();
        t_wait();
        t_status();
        t_audio();
        give_verdict();
    end
endmodule
bind card_socket_ctrl card_socket_ctrl_sva i_card_socket_ctrl_sva (.clk, .reset_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .wait_n, .even_byte_select_n,
    .odd_byte_select_n, .attr_select_n, .output_enable_n, .write_enable_n, .io_read_strobe_n,
    .io_write_strobe_n);
`default_nettype wire

/* pc_card_model.sv */
// behavioural 16-bit card as seen from one socket
`timescale 1ns/1ps
`default_nettype none
module pc_card_model (
    input wire logic clk,
    input wire logic inserted,
    input wire logic io_card,
    input wire logic [1:0] batt,
    input wire logic ready,
    input wire logic irq_n,
    input wire logic change_n,
    input wire logic audio,
    input wire logic [7:0] wait_len,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic io_rd_n,
    input wire logic io_wr_n,
    output logic batt_1,
    output logic batt_2,
    output logic present_1,
    output logic present_2,
    output logic rdy_irq,
    output logic wait_n,
    output logic ack_n
);
    logic [7:0] cnt_reg = 8'h00;
    wire logic strobe = !(oe_n && we_n && io_rd_n && io_wr_n);
    // an empty socket lets every line float to its pull-up level
    assign present_1 = !inserted;
    assign present_2 = !inserted;
    assign batt_1 = !inserted || (io_card ? change_n : batt[0]);
    assign batt_2 = !inserted || (io_card ? audio : batt[1]);
    assign rdy_irq = !inserted || (io_card ? irq_n : ready);
    assign ack_n = !(inserted && io_card && !io_rd_n);
    assign wait_n = !(inserted && strobe && cnt_reg < wait_len);
    always_ff @(posedge clk) begin
        cnt_reg <= strobe ? cnt_reg + 8'h01 : 8'h00;
    end
endmodule
`default_nettype wire

/* pin_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= INIT;
            pin_out <= INIT;
        end else begin
            meta_reg <= pin_in;
            pin_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* socket_engine.sv */
// one socket: input routing, status-change capture and strobe sequencer
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module socket_engine
    import card_socket_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic io_mode,
    input wire logic audio_en,
    input wire logic [3:0] chg_enable,
    input wire logic chg_clear,
    input wire logic [3:0] chg_clear_mask,
    input wire logic start,
    input wire logic [1:0] kind,
    input wire logic attr,
    input wire logic even_req,
    input wire logic odd_req,
    input wire logic battery_detect_1,
    input wire logic battery_detect_2,
    input wire logic card_present_1,
    input wire logic card_present_2,
    input wire logic ready_irq_in,
    input wire logic wait_n,
    input wire logic input_acknowledge_n,
    output logic [3:0] chg_flags,
    output logic chg_event,
    output logic [7:0] status,
    output logic busy,
    output logic ack_seen,
    output logic audio,
    output logic even_byte_select_n,
    output logic odd_byte_select_n,
    output logic attr_select_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic io_read_strobe_n,
    output logic io_write_strobe_n
);
    // ************************************
    // input routing
    // ************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STROBE = 3'b010,
        ST_RELEASE = 3'b100
    } state_t;
    state_t state_reg, state_next;
    logic [7:0] count_reg;
    logic [1:0] kind_reg;
    logic present, batt_good, batt_weak, batt_dead, ready;
    logic status_change_in, card_audio_in, ring_indicate, card_interrupt_request;
    logic [3:0] cond, cond_prev_reg, chg_set;
    assign present = !card_present_1 && !card_present_2;
    assign batt_good = !io_mode && battery_detect_1 && battery_detect_2;
    assign batt_weak = !io_mode && battery_detect_1 && !battery_detect_2;
    assign batt_dead = !io_mode && !battery_detect_1;
    assign ready = !io_mode && ready_irq_in;
    assign status_change_in = io_mode && !battery_detect_1;
    assign ring_indicate = status_change_in;
    assign card_audio_in = io_mode && battery_detect_2;
    assign card_interrupt_request = io_mode && !ready_irq_in;
    // in io mode a status-change assertion is reported on the dead position
    assign cond = {ready, batt_weak, batt_dead | status_change_in, present};
    assign chg_set = (cond ^ cond_prev_reg) & chg_enable;
    assign status = {card_interrupt_request, ring_indicate, batt_good, batt_weak,
                     batt_dead, ready, card_present_2, card_present_1};
    // ************************************
    // status-change capture
    // ************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cond_prev_reg <= 4'h0;
            chg_flags <= 4'h0;
            chg_event <= 1'b0;
            audio <= 1'b0;
        end else begin
            cond_prev_reg <= cond;
            // set wins over a simultaneous clear
            chg_flags <= (chg_flags & ~(chg_clear ? chg_clear_mask : 4'h0)) | chg_set;
            chg_event <= |chg_set;
            audio <= audio_en && card_audio_in;
        end
    end
    // ************************************
    // strobe sequencer
    // ************************************
    logic strobe_done;
    assign strobe_done = (count_reg == 8'h00) && wait_n;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (strobe_done) begin
                    state_next = ST_RELEASE;
                end
            end
            ST_RELEASE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end
    logic active;
    assign active = (state_next == ST_STROBE);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            count_reg <= 8'h00;
            kind_reg <= 2'h0;
            ack_seen <= 1'b0;
            even_byte_select_n <= 1'b1;
            odd_byte_select_n <= 1'b1;
            attr_select_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            io_read_strobe_n <= 1'b1;
            io_write_strobe_n <= 1'b1;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && start) begin
                kind_reg <= kind;
                count_reg <= STROBE_COUNT - 8'h01;
                ack_seen <= 1'b0;
                even_byte_select_n <= !even_req;
                odd_byte_select_n <= !odd_req;
                attr_select_n <= !(attr || kind[1]);
            end else if (state_reg == ST_STROBE && count_reg != 8'h00) begin
                count_reg <= count_reg - 8'h01;
            end
            if (state_reg == ST_STROBE && kind_reg == KIND_IO_RD && !input_acknowledge_n) begin
                ack_seen <= 1'b1;
            end
            if (state_next == ST_IDLE) begin
                even_byte_select_n <= 1'b1;
                odd_byte_select_n <= 1'b1;
                attr_select_n <= 1'b1;
            end
            output_enable_n <= !(active && kind_next_sel(KIND_MEM_RD));
            write_enable_n <= !(active && kind_next_sel(KIND_MEM_WR));
            io_read_strobe_n <= !(active && kind_next_sel(KIND_IO_RD));
            io_write_strobe_n <= !(active && kind_next_sel(KIND_IO_WR));
        end
    end
    function automatic logic kind_next_sel(input logic [1:0] k);
        kind_next_sel = (state_reg == ST_IDLE) ? (kind == k) : (kind_reg == k);
    endfunction
    assign busy = (state_reg != ST_IDLE);
endmodule
`default_nettype wire
